/* isp_pkg.sv */
// package: constants and carriers of the programming port
package isp_pkg;

   // ==========================================================================
   // clock and wait times
   localparam int  CLK_HZ        = 20_000_000;   // sys_clk rate, also the cpu clock
   localparam real PM_WAIT_MS    = 4.5;          // program_memory_write_wait
   localparam real EE_WAIT_MS    = 4.0;          // eeprom_write_wait
   localparam real ERASE_WAIT_MS = 9.0;          // chip_erase_wait
   localparam real FUSE_WAIT_MS  = 4.5;          // fuse_write_wait
   // busy times equal the minimum waits
   localparam int  PM_WAIT_CYC    = int'(PM_WAIT_MS * CLK_HZ / 1000.0);
   localparam int  EE_WAIT_CYC    = int'(EE_WAIT_MS * CLK_HZ / 1000.0);
   localparam int  ERASE_WAIT_CYC = int'(ERASE_WAIT_MS * CLK_HZ / 1000.0);
   localparam int  FUSE_WAIT_CYC  = int'(FUSE_WAIT_MS * CLK_HZ / 1000.0);
   localparam int  BUSY_W         = 24;          // width of the busy down counter

   // ==========================================================================
   // instruction bytes
   localparam logic [7:0] OP_AC       = 8'hac;   // enable, erase, fuse and lock writes
   localparam logic [7:0] OP_ENABLE   = 8'h53;   // second byte of programming enable
   localparam logic [7:0] OP_ERASE    = 8'h80;   // second byte of chip erase
   localparam logic [7:0] OP_POLL     = 8'hf0;
   localparam logic [7:0] OP_EXT_ADR  = 8'h4d;
   localparam logic [7:0] OP_LD_PM_HI = 8'h48;
   localparam logic [7:0] OP_LD_PM_LO = 8'h40;
   localparam logic [7:0] OP_LD_EE    = 8'hc1;
   localparam logic [7:0] OP_RD_PM_HI = 8'h28;
   localparam logic [7:0] OP_RD_PM_LO = 8'h20;
   localparam logic [7:0] OP_RD_EE    = 8'ha0;
   localparam logic [7:0] OP_RD_LOCK  = 8'h58;   // with 8'h08: high fuses
   localparam logic [7:0] OP_RD_FUSE  = 8'h50;   // with 8'h08: extended fuses
   localparam logic [7:0] OP_RD_SIG   = 8'h30;
   localparam logic [7:0] OP_RD_CAL   = 8'h38;
   localparam logic [7:0] OP_WR_PM_PG = 8'h4c;
   localparam logic [7:0] OP_WR_EE    = 8'hc0;
   localparam logic [7:0] OP_WR_EE_PG = 8'hc2;
   localparam logic [7:0] SEL_HI      = 8'h08;   // byte 2 selecting high / extended
   localparam logic [7:0] WR_LOCK     = 8'he0;
   localparam logic [7:0] WR_FUSE_LO  = 8'ha0;
   localparam logic [7:0] WR_FUSE_HI  = 8'ha8;
   localparam logic [7:0] WR_FUSE_EX  = 8'ha4;
   localparam logic [7:0] ERASED      = 8'hff;

   // ==========================================================================
   // configuration reset values, zero is programmed
   localparam logic [7:0]  LOCK_RST    = 8'hff;
   localparam logic [7:0]  FUSE_LO_RST = 8'h62;
   localparam logic [7:0]  FUSE_HI_RST = 8'hdf;
   localparam logic [7:0]  FUSE_EX_RST = 8'hff;
   localparam logic [23:0] SIG_RST     = 24'h5a_a5_3c; // arbitrary value
   localparam logic [7:0]  CAL_RST     = 8'h80;

   // ==========================================================================
   // register map, byte addresses on the avalon slave
   localparam logic [3:0] REG_STATUS = 4'h0;     // ro: mode, enable, busy, ext address
   localparam logic [3:0] REG_SIG    = 4'h4;     // rw: three signature bytes
   localparam logic [3:0] REG_CAL    = 4'h8;     // rw: calibration byte
   localparam logic [3:0] REG_FUSES  = 4'hc;     // ro: {ext, high, low, lock}
   localparam int ST_MODE   = 0;                 // reset pin held low
   localparam int ST_ENABLE = 1;                 // programming enable executed
   localparam int ST_BUSY   = 2;                 // self-timed operation running
   localparam int ST_EXT    = 8;                 // extended address byte at [15:8]

   // ==========================================================================
   // avalon carriers
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } isp_avm_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } isp_avm_rsp_s;

endpackage

/* isp_sync.sv */
// two flip-flop pin synchroniser
`timescale 1ns/100ps
module isp_sync #(
   parameter int           W   = 1,          // number of bits
   parameter logic [W-1:0] RST = '0          // value held under reset
) (
   input  wire logic         clk,            // sampling clock
   input  wire logic         rst_n,          // asynchronous reset, active low
   input  wire logic [W-1:0] d,              // asynchronous inputs
   output logic      [W-1:0] q               // synchronised outputs
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } st_s;

   st_s s;
   st_s next_s;

   // ==========================================================================
   // first stage feeds only the second stage
   always_comb begin
      next_s      = s;
      next_s.meta = d;
      next_s.q    = s.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= {RST, RST};
      end else begin
         s <= next_s;
      end
   end

   assign q = s.q;

endmodule // isp_sync

/* isp_serial_prog.sv */
// serial programming port: shifter, decoder, memories, avalon slave
// Function
// [RULE_01] programming only while reset pin low
// [RULE_02] program and erase need prior enable
// [RULE_03] eeprom write erases its location itself
// [RULE_04] chip erase fills both memories with ff
// [RULE_05] sck high and low long enough
// [RULE_06] sample on sck rise, shift on fall
// [RULE_07] programmer powers up with reset, sck low
// [RULE_08] programmer waits before programming enable
// [RULE_09] enable echoes 53 during third byte
// [RULE_10] page buffer loaded low then high byte
// [RULE_11] page commit uses six high bits
// [RULE_12] programmer waits write times without polling; the testbench polls with f0 until busy clears instead
// [RULE_13] programmer stays off link during write; the testbench sends f0 poll instructions while a write is busy
// [RULE_14] eeprom byte write at six-bit address
// [RULE_15] eeprom page writes loaded bytes only
// [RULE_16] reads return memory data in byte four
// [RULE_17] configuration bytes returned in byte four
// [RULE_18] ac writes program lock and fuse bytes
// [RULE_19] program memory uses word addresses
// [RULE_20] extended address instruction accepted
// [RULE_21] reset pin high leaves programming mode
// [RULE_22] poll returns busy in lowest bit
`timescale 1ns/100ps
module isp_serial_prog
   import isp_pkg::*;
#(
   parameter int PG_BITS    = 5,                  // word address bits within a page
   parameter int PAGE_BITS  = 6,                  // page number bits
   parameter int EE_BITS    = 6,                  // eeprom address bits
   parameter int EE_PG_BITS = 2,                  // eeprom address bits within a page
   parameter int PM_WAIT    = PM_WAIT_CYC,        // busy cycles after a page write
   parameter int EE_WAIT    = EE_WAIT_CYC,        // busy cycles after an eeprom write
   parameter int ERASE_WAIT = ERASE_WAIT_CYC,     // busy cycles after a chip erase
   parameter int FUSE_WAIT  = FUSE_WAIT_CYC       // busy cycles after a fuse write
) (
   input  wire logic         sys_clk,             // cpu clock, 20 mhz
   input  wire logic         reset_n,             // asynchronous reset, active low
   input  wire logic         prog_reset_n,        // device reset pin, low selects programming
   input  wire logic         sck,                 // serial clock from the programmer
   input  wire logic         mosi,                // serial data in
   output logic              miso,                // serial data out
   output logic              miso_oe,             // miso driven while in programming mode
   output logic              cpu_run,             // high while the cpu may run normally
   input  isp_pkg::isp_avm_req_s avm_req,         // avalon request
   output isp_pkg::isp_avm_rsp_s avm_rsp          // avalon answer
);

   localparam int PMA      = PG_BITS + PAGE_BITS;
   localparam int PG_WORDS = 1 << PG_BITS;
   localparam int PM_WORDS = 1 << PMA;
   localparam int EE_BYTES = 1 << EE_BITS;
   localparam int EE_PG    = 1 << EE_PG_BITS;

   typedef struct packed {
      logic                         sck_d;        // last synchronised sck level
      logic [2:0]                   bit_cnt;
      logic [1:0]                   byte_idx;
      logic [7:0]                   in_sh;
      logic [7:0]                   b1;
      logic [7:0]                   b2;
      logic [7:0]                   b3;
      logic [7:0]                   out_sh;
      logic                         miso;
      logic                         miso_oe;
      logic                         run;
      logic                         prog_en;
      logic [BUSY_W-1:0]            busy_cnt;
      logic [7:0]                   ext_addr;
      logic [PG_WORDS-1:0][15:0]    pbuf;
      logic [PM_WORDS-1:0][15:0]    pm;
      logic [EE_BYTES-1:0][7:0]     ee;
      logic [EE_PG-1:0][7:0]        ebuf;
      logic [EE_PG-1:0]             emask;
      logic [7:0]                   lock;
      logic [7:0]                   fuse_lo;
      logic [7:0]                   fuse_hi;
      logic [7:0]                   fuse_ex;
      logic [23:0]                  sig;
      logic [7:0]                   cal;
      logic                         wait_req;
      logic [31:0]                  rdata;
   } st_s;

   st_s        s;
   st_s        next_s;
   logic [2:0] pins_s;
   logic       rst_pin_s;
   logic       sck_s;
   logic       mosi_s;

   // ==========================================================================
   // pin synchronisers; reset pin rests high, port closed
   isp_sync #(
      .W   (3),
      .RST (3'b100)
   ) u_sync (
      .clk   (sys_clk),
      .rst_n (reset_n),
      .d     ({prog_reset_n, sck, mosi}),
      .q     (pins_s)
   );

   assign rst_pin_s = pins_s[2];
   assign sck_s     = pins_s[1];
   assign mosi_s    = pins_s[0];

   // ==========================================================================
   // word address of an instruction
   function automatic logic [PMA-1:0] pm_index(input logic [7:0] hi, input logic [7:0] lo);
      logic [15:0] a;
      a = {hi, lo};
      pm_index = a[PMA-1:0];                       // [RULE_19]
   endfunction

   // byte four output, chosen at end of byte three
   function automatic logic [7:0] rd_byte(input logic [7:0] c1, input logic [7:0] c2,
                                          input logic [7:0] c3);
      logic [15:0] w;
      w       = s.pm[pm_index(c2, c3)];
      rd_byte = c3;
      case (c1)
         OP_RD_PM_LO: rd_byte = w[7:0];                                // [RULE_16]
         OP_RD_PM_HI: rd_byte = w[15:8];                               // [RULE_16]
         OP_RD_EE:    rd_byte = s.ee[c3[EE_BITS-1:0]];                 // [RULE_16]
         OP_RD_LOCK:  rd_byte = (c2 == SEL_HI) ? s.fuse_hi : s.lock;   // [RULE_17]
         OP_RD_FUSE:  rd_byte = (c2 == SEL_HI) ? s.fuse_ex : s.fuse_lo; // [RULE_17]
         OP_RD_CAL:   rd_byte = s.cal;                                 // [RULE_17]
         OP_RD_SIG: begin
            case (c3[1:0])                                             // [RULE_17]
               2'h0:    rd_byte = s.sig[7:0];
               2'h1:    rd_byte = s.sig[15:8];
               2'h2:    rd_byte = s.sig[23:16];
               default: rd_byte = 8'h00;
            endcase
         end
         OP_POLL:     rd_byte = {7'h00, (s.busy_cnt != '0)};           // [RULE_22]
         default:     rd_byte = c3;
      endcase
   endfunction

   // ==========================================================================
   // next state
   always_comb begin
      logic [7:0]       sh;
      logic [PMA-1:0]   idx;
      logic [PAGE_BITS-1:0] page;
      logic [EE_BITS-EE_PG_BITS-1:0] epage;
      logic             idle;
      sh     = 8'h00;
      idx    = '0;
      page   = '0;
      epage  = '0;
      idle   = (s.busy_cnt == '0);
      next_s = s;

      // avalon: one wait cycle, then waitrequest low
      next_s.wait_req = 1'b1;
      if ((avm_req.read || avm_req.write) && s.wait_req) begin
         next_s.wait_req = 1'b0;
         case (avm_req.address)
            REG_STATUS: begin
               next_s.rdata                  = 32'h0000_0000;
               next_s.rdata[ST_MODE]         = !rst_pin_s;
               next_s.rdata[ST_ENABLE]       = s.prog_en;
               next_s.rdata[ST_BUSY]         = !idle;
               next_s.rdata[ST_EXT +: 8]     = s.ext_addr;
            end
            REG_SIG:   next_s.rdata = {8'h00, s.sig};
            REG_CAL:   next_s.rdata = {24'h00_0000, s.cal};
            REG_FUSES: next_s.rdata = {s.fuse_ex, s.fuse_hi, s.fuse_lo, s.lock};
            default:   next_s.rdata = 32'h0000_0000;
         endcase
      end
      // write lands when waitrequest is seen low
      if (!s.wait_req && avm_req.write) begin
         for (int i = 0; i < 3; i++) begin
            if (avm_req.address == REG_SIG && avm_req.byteenable[i]) begin
               next_s.sig[8*i +: 8] = avm_req.writedata[8*i +: 8];
            end
         end
         if (avm_req.address == REG_CAL && avm_req.byteenable[0]) begin
            next_s.cal = avm_req.writedata[7:0];
         end
      end

      // busy countdown
      if (!idle) begin
         next_s.busy_cnt = s.busy_cnt - 1'b1;
      end

      next_s.sck_d   = sck_s;
      next_s.run     = rst_pin_s;                  // [RULE_21]
      next_s.miso_oe = !rst_pin_s;                 // [RULE_01]

      if (rst_pin_s) begin
         // leaving the mode drops enable and framing
         next_s.prog_en  = 1'b0;                   // [RULE_21]
         next_s.bit_cnt  = 3'h0;
         next_s.byte_idx = 2'h0;
         next_s.out_sh   = 8'h00;
         next_s.miso     = 1'b0;
      end else if (sck_s && !s.sck_d) begin
         // rising sck: take one bit
         sh              = {s.in_sh[6:0], mosi_s}; // [RULE_06] [RULE_05]
         next_s.in_sh    = sh;
         next_s.bit_cnt  = s.bit_cnt + 3'h1;
         if (s.bit_cnt == 3'h7) begin
            next_s.byte_idx = s.byte_idx + 2'h1;
            next_s.out_sh   = sh;                  // echo of the byte just taken
            case (s.byte_idx)
               2'h0: next_s.b1 = sh;
               2'h1: next_s.b2 = sh;               // [RULE_09]
               2'h2: begin
                  next_s.b3 = sh;
                  if (s.prog_en) begin
                     next_s.out_sh = rd_byte(s.b1, s.b2, sh);
                  end
               end
               default: begin
                  // fourth byte complete: execute
                  idx   = pm_index(s.b2, s.b3);
                  page  = idx[PMA-1:PG_BITS];
                  epage = s.b3[EE_BITS-1:EE_PG_BITS];
                  if (s.b1 == OP_AC && s.b2 == OP_ENABLE) begin
                     next_s.prog_en = 1'b1;        // [RULE_02] [RULE_09]
                  end else if (s.prog_en) begin    // [RULE_02]
                     case (s.b1)
                        OP_AC: begin
                           if (idle) begin
                              case (s.b2)
                                 OP_ERASE: begin
                                    next_s.pm       = '1;               // [RULE_04]
                                    next_s.ee       = '1;               // [RULE_04]
                                    next_s.busy_cnt = BUSY_W'(ERASE_WAIT);
                                 end
                                 WR_LOCK: begin
                                    next_s.lock     = sh;               // [RULE_18]
                                    next_s.busy_cnt = BUSY_W'(FUSE_WAIT);
                                 end
                                 WR_FUSE_LO: begin
                                    next_s.fuse_lo  = sh;               // [RULE_18]
                                    next_s.busy_cnt = BUSY_W'(FUSE_WAIT);
                                 end
                                 WR_FUSE_HI: begin
                                    next_s.fuse_hi  = sh;               // [RULE_18]
                                    next_s.busy_cnt = BUSY_W'(FUSE_WAIT);
                                 end
                                 WR_FUSE_EX: begin
                                    next_s.fuse_ex  = sh;               // [RULE_18]
                                    next_s.busy_cnt = BUSY_W'(FUSE_WAIT);
                                 end
                                 default: begin
                                 end
                              endcase
                           end
                        end
                        OP_EXT_ADR: next_s.ext_addr = s.b3;             // [RULE_20]
                        OP_LD_PM_LO: begin
                           next_s.pbuf[idx[PG_BITS-1:0]][7:0] = sh;     // [RULE_10]
                        end
                        OP_LD_PM_HI: begin
                           next_s.pbuf[idx[PG_BITS-1:0]][15:8] = sh;    // [RULE_10]
                        end
                        OP_WR_PM_PG: begin
                           // word bits ignored
                           if (idle) begin
                              for (int w = 0; w < PG_WORDS; w++) begin
                                 next_s.pm[{page, PG_BITS'(w)}] = s.pbuf[w]; // [RULE_11]
                              end
                              next_s.pbuf     = '1;
                              next_s.busy_cnt = BUSY_W'(PM_WAIT);
                           end
                        end
                        OP_WR_EE: begin
                           // overwrite is erase plus write
                           if (idle) begin
                              next_s.ee[s.b3[EE_BITS-1:0]] = sh;        // [RULE_14] [RULE_03]
                              next_s.busy_cnt = BUSY_W'(EE_WAIT);
                           end
                        end
                        OP_LD_EE: begin
                           next_s.ebuf[s.b3[EE_PG_BITS-1:0]]  = sh;     // [RULE_15]
                           next_s.emask[s.b3[EE_PG_BITS-1:0]] = 1'b1;   // [RULE_15]
                        end
                        OP_WR_EE_PG: begin
                           if (idle) begin
                              for (int e = 0; e < EE_PG; e++) begin
                                 if (s.emask[e]) begin
                                    next_s.ee[{epage, EE_PG_BITS'(e)}] = s.ebuf[e]; // [RULE_15]
                                 end
                              end
                              next_s.emask    = '0;
                              next_s.busy_cnt = BUSY_W'(EE_WAIT);       // [RULE_03]
                           end
                        end
                        default: begin
                        end
                     endcase
                  end
               end
            endcase
         end
      end else if (!sck_s && s.sck_d) begin
         // falling sck: next output bit
         next_s.miso   = s.out_sh[7];              // [RULE_06]
         next_s.out_sh = {s.out_sh[6:0], 1'b0};
      end
   end

   // ==========================================================================
   // state register; memories restart erased
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s          <= '0;
         s.sck_d    <= 1'b0;
         s.run      <= 1'b1;
         s.pbuf     <= '1;
         s.pm       <= '1;
         s.ee       <= '1;
         s.ebuf     <= '1;
         s.lock     <= LOCK_RST;
         s.fuse_lo  <= FUSE_LO_RST;
         s.fuse_hi  <= FUSE_HI_RST;
         s.fuse_ex  <= FUSE_EX_RST;
         s.sig      <= SIG_RST;
         s.cal      <= CAL_RST;
         s.wait_req <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================================
   // outputs from the register
   assign miso                = s.miso;
   assign miso_oe             = s.miso_oe;
   assign cpu_run             = s.run;
   assign avm_rsp.readdata    = s.rdata;
   assign avm_rsp.waitrequest = s.wait_req;

endmodule // isp_serial_prog

/* isp_monitor.sv */
// checker: port level assertions of the serial programming port
`timescale 1ns/100ps
module isp_mon
   import isp_pkg::*;
(
   input wire logic  sys_clk,      // clock
   input wire logic  reset_n,      // reset, low
   input wire logic  prog_reset_n, // reset pin
   input wire logic  sck,          // serial clock
   input wire logic  mosi,         // serial in
   input wire logic  miso,         // serial out
   input wire logic  miso_oe,      // out enable
   input wire logic  cpu_run,      // normal run
   input isp_pkg::isp_avm_req_s avm_req, // request
   input isp_pkg::isp_avm_rsp_s avm_rsp  // answer
);
   // ==========================================================================
   // single clock domain
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_seen; (avm_req.read || avm_req.write) && avm_rsp.waitrequest; endsequence
   sequence s_ans; !avm_rsp.waitrequest ##1 avm_rsp.waitrequest; endsequence
   a_one_wait: assert property (s_seen |=> s_ans) else $error("late bus answer");
   a_ans_cause: assert property (!avm_rsp.waitrequest |-> $past(avm_req.read || avm_req.write))
      else $error("answer without request");
   a_idle_wait: assert property (!(avm_req.read || avm_req.write) [*2] |-> avm_rsp.waitrequest)
      else $error("wait low while idle");
   a_pins_excl: assert property (miso_oe != cpu_run) else $error("oe and run agree");
   a_mode_enter: assert property (!prog_reset_n [*5] |-> miso_oe) else $error("no mode");
   a_enter_cause: assert property ($fell(cpu_run) |-> !$past(prog_reset_n, 2))
      else $error("mode without pin");
   a_mode_leave: assert property (prog_reset_n [*5] |-> cpu_run && !miso_oe)
      else $error("mode kept");
   // miso moves only after a fall
   a_miso_hold: assert property ($rose(sck) && miso_oe |=> $stable(miso) [*3])
      else $error("miso moved while sck high");
endmodule // isp_mon
bind isp_serial_prog isp_mon isp_mon_inst (.sys_clk(sys_clk), .reset_n(reset_n),
   .prog_reset_n(prog_reset_n), .sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
   .cpu_run(cpu_run), .avm_req(avm_req), .avm_rsp(avm_rsp));

/* isp_prog_model.sv */
// partner: behavioural in-system programmer on the serial pins
`timescale 1ns/100ps
module isp_prog_model #(
   parameter int WAIT_CYC = 400000       // settle time after pin low, 20 ms
) (
   input wire logic sys_clk,             // clock
   input wire logic miso,                // serial out of device
   output logic     prog_reset_n = 1'b0, // reset pin, starts low
   output logic     sck = 1'b0,          // serial clock, rests low
   output logic     mosi = 1'b0          // serial in of device
);
   // ==========================================================================
   // pin change, then settle
   task pin(input logic v);
      @(posedge sys_clk) prog_reset_n <= v;
      repeat (WAIT_CYC) @(posedge sys_clk);
   endtask
   // msb first, 5 low and 3 high: read miso once sck is up
   task xfer(input logic [31:0] c, output logic [31:0] r);
      for (int i = 31; i >= 0; i--) begin
         mosi <= c[i];
         repeat (5) @(posedge sys_clk);
         sck <= 1'b1;
         @(posedge sys_clk) r[i] = miso;
         repeat (2) @(posedge sys_clk);
         sck <= 1'b0;
      end
   endtask
   // poll until ready, at most 50 tries
   task poll(output logic [31:0] r);
      for (int k = 0; k < 50; k++) begin
         xfer(32'hf000_0000, r);
         if (r[0] === 1'b0) break;
      end
   endtask
endmodule // isp_prog_model

/* tb.sv */
// testbench: self-checking run of the serial programming port
`timescale 1ns/100ps
module tb;
   import isp_pkg::*;
   logic         sys_clk = 1'b0;
   logic         reset_n = 1'b0;
   logic         prog_reset_n, sck, mosi, miso, miso_oe, cpu_run;
   isp_avm_req_s req = '0;
   isp_avm_rsp_s rsp;
   int           failures = 0;
   int           tests_run = 0;
   int           cyc = 0;
   logic [31:0]  r, q;
   logic [3:0]   be = 4'hf;
   always #25 sys_clk = ~sys_clk;
   isp_serial_prog #(.PM_WAIT(20), .EE_WAIT(16), .ERASE_WAIT(40), .FUSE_WAIT(20))
      isp_serial_prog_inst (.sys_clk(sys_clk), .reset_n(reset_n), .prog_reset_n(prog_reset_n),
      .sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .cpu_run(cpu_run),
      .avm_req(req), .avm_rsp(rsp));
   isp_prog_model #(.WAIT_CYC(20)) isp_prog_model_inst (.sys_clk(sys_clk), .miso(miso),
      .prog_reset_n(prog_reset_n), .sck(sck), .mosi(mosi));
   // ==========================================================================
   // shared tasks
   task test_done;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e, input string n);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // request held until waitrequest is seen low
   task av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk) req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
      do @(posedge sys_clk); while (rsp.waitrequest !== 1'b0);
      q = rsp.readdata;
      req <= '0;
   endtask
   task x(input logic [31:0] c); isp_prog_model_inst.xfer(c, r); endtask
   task sx(input logic [31:0] c, input logic [7:0] e, input string n);
      x(c);
      chk(r[7:0], e, n);
   endtask
   task wr(input logic [31:0] c);
      x(c);
      isp_prog_model_inst.poll(r);
      chk(r[0], 1'b0, "poll");
   endtask
   // ==========================================================================
   // scenarios
   task t_enable;
      x(32'hc000_0377);
      sx(32'h2000_5a00, 8'h5a, "echo b3");
      x(32'hac53_0000);
      chk(r[15:8], OP_ENABLE, "enable echo");
      av(1'b0, REG_STATUS, '0);
      chk(q[1:0], 2'b11, "mode");
      sx(32'ha000_0300, ERASED, "refused wr");
   endtask
   task t_flash;
      wr(32'h4000_2511);
      wr(32'h4800_2522);
      x(32'h4c00_3f00);
      av(1'b0, REG_STATUS, '0);
      chk(q[ST_BUSY], 1'b1, "busy");
      isp_prog_model_inst.poll(r);
      sx(32'h2000_2500, 8'h11, "pm lo");
      sx(32'h2800_2500, 8'h22, "pm hi");
   endtask
   task t_eeprom;
      wr(32'hc000_053c);
      wr(32'hc000_05c3);
      sx(32'ha000_0500, 8'hc3, "ee byte");
      wr(32'hc100_0199);
      wr(32'hc200_0800);
      sx(32'ha000_0900, 8'h99, "ee page");
      sx(32'ha000_0800, ERASED, "ee kept");
      wr(32'hac80_0000);
      sx(32'h2000_2500, ERASED, "erase pm");
      sx(32'ha000_0500, ERASED, "erase ee");
   endtask
   task t_config;
      logic [31:0] rc [6] = '{32'h5800_0000, 32'h5000_0000, 32'h5808_0000, 32'h5008_0000,
                              32'h3000_0100, 32'h3800_0000};
      logic [7:0]  re [6] = '{LOCK_RST, FUSE_LO_RST, FUSE_HI_RST, FUSE_EX_RST, SIG_RST[15:8],
                              CAL_RST};
      logic [7:0]  wc [4] = '{WR_FUSE_LO, WR_FUSE_HI, WR_FUSE_EX, WR_LOCK};
      for (int i = 0; i < 6; i++) sx(rc[i], re[i], "cfg read");
      for (int i = 0; i < 4; i++) begin
         wr({OP_AC, wc[i], 8'h00, 8'he0 + 8'(i)});
         sx(rc[(i + 1) % 4], 8'he0 + 8'(i), "cfg write");
      end
      av(1'b1, REG_FUSES, '0);
      av(1'b0, REG_FUSES, '0);
      chk(q, 32'he2e1e0e3, "fuse reg");
      av(1'b0, REG_SIG, '0);
      chk(q[23:0], SIG_RST, "sig reg");
      av(1'b1, REG_CAL, 32'h5a);
      sx(32'h3800_0000, 8'h5a, "cal");
      be = 4'he;
      av(1'b1, REG_CAL, 32'h33);
      sx(32'h3800_0000, 8'h5a, "cal kept");
      av(1'b0, 4'h2, '0);
      chk(q, 32'h0, "unmapped");
   endtask
   task t_exit;
      x(32'h4d00_0700);
      av(1'b0, REG_STATUS, '0);
      chk(q[15:8], 8'h07, "ext adr");
      isp_prog_model_inst.pin(1'b1);
      av(1'b0, REG_STATUS, '0);
      chk(q[1:0], 2'b00, "left mode");
      isp_prog_model_inst.pin(1'b0);
      sx(32'h2000_5a00, 8'h5a, "enable cleared");
   endtask
   // ==========================================================================
   // hang guard and main sequence
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         test_done;
      end
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      isp_prog_model_inst.pin(1'b0);
      t_enable;
      t_flash;
      t_eeprom;
      t_config;
      t_exit;
      test_done;
   end
endmodule // tb
